// ===== hdl/cantrx_mode_ctrl.sv
// Transceiver mode control, pin behaviour and AXI4-Lite register slave
//
// Overview of operation
// - Power-up mode is off; off is selectable in every system mode, halts bus.
// - In off mode bus wake activity is ignored and gives no wake.
// - Normal mode entered only by register write, only in normal system mode.
// - In normal mode bus drive follows transmit input: high recessive, low dominant.
// - After enabling, no dominant reaches the bus until enabling interval ends.
// - Low input during interval is suppressed until the first new dominant bit.
// - In normal and receive-only modes receive output gives a continuous digital image of the bus state.
// - Receive-only mode keeps driver off, receiver keeps delivering bus levels.
// - Receive-only selectable in normal or stop system mode.
// - Receive-only reception works without transceiver supply pin powered.
// - Wake-capable mode lets bus activity wake the chip.
// - Supports bit rates up to 5 Mbaud including flexible data rate frames.
// - Mode field reads 01 in wake-capable mode, also after wake.
// - After wake pattern receive output is held low until mode changes or system mode changes into stop or fail-safe.
`timescale 1ns/1ps
`default_nettype none

module cantrx_mode_ctrl #(
   parameter int EN_CYCLES = cantrx_pkg::EN_CYCLES
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // AXI4-Lite write address
   input wire logic [cantrx_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   // AXI4-Lite write data
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read address
   input wire logic [cantrx_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // System context
   input wire logic [2:0] sys_mode,
   input wire logic transceiver_supply_pin,
   // Controller side pins
   input wire logic bus_transmit_input,
   output logic bus_receive_output,
   // Analog front end
   input wire logic bus_dominant_seen,
   input wire logic wake_pattern_seen,
   output logic bus_drive_dominant,
   output logic driver_enable,
   output logic wake_event,
   // Interrupt
   output logic irq
);

   // --------------------------------------------------------------
   // Parameter checks
   // --------------------------------------------------------------
   localparam int CW = $clog2(EN_CYCLES + 1);
   localparam logic [CW-1:0] EN_LAST = CW'(EN_CYCLES - 1);
   initial begin
      if (EN_CYCLES < 1) begin
         $error("EN_CYCLES must be at least one");
      end
   end

   // --------------------------------------------------------------
   // State
   // --------------------------------------------------------------
   typedef struct packed {
      logic [1:0] mode;
      logic [CW-1:0] en_cnt;
      logic en_done;
      logic tx_block;
      logic woken;
      logic wake_evt;
      logic [2:0] sys_prev;
      logic [cantrx_pkg::IRQ_W-1:0] irq_stat;
      logic [cantrx_pkg::IRQ_W-1:0] irq_mask;
      cantrx_pkg::cantrx_wr_t wr;
      logic [1:0] bresp;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } cantrx_state_t;

   cantrx_state_t st;
   cantrx_state_t next_st;

   logic wr_go;
   logic rd_go;
   logic [1:0] req_mode;
   logic allowed;
   logic [31:0] stat_word;

   // Both write channels are taken together so no address or data is held
   assign wr_go = s_axi_awvalid && s_axi_wvalid && (st.wr == cantrx_pkg::WR_IDLE);
   assign s_axi_awready = wr_go;
   assign s_axi_wready = wr_go;
   assign s_axi_bvalid = (st.wr == cantrx_pkg::WR_RESP);
   assign s_axi_bresp = st.bresp;
   assign rd_go = s_axi_arvalid && !st.rvalid;
   assign s_axi_arready = rd_go;
   assign s_axi_rvalid = st.rvalid;
   assign s_axi_rdata = st.rdata;
   assign s_axi_rresp = st.rresp;

   // --------------------------------------------------------------
   // Mode permission
   // --------------------------------------------------------------
   // Permission of a requested mode against the system mode
   always_comb begin
      req_mode = s_axi_wdata[cantrx_pkg::CTRL_MODE_LSB +: 2];
      case (req_mode)
         cantrx_pkg::MODE_OFF: allowed = 1'b1;
         cantrx_pkg::MODE_NORMAL: allowed = (sys_mode == cantrx_pkg::SYS_NORMAL);
         cantrx_pkg::MODE_RXONLY: allowed = (sys_mode == cantrx_pkg::SYS_NORMAL) ||
                                            (sys_mode == cantrx_pkg::SYS_STOP);
         cantrx_pkg::MODE_WAKE: allowed = 1'b1;
         default: allowed = 1'b0;
      endcase
   end

   // Status word shown to software
   always_comb begin
      stat_word = 32'h0;
      stat_word[cantrx_pkg::CTRL_MODE_LSB +: 2] = st.mode;
      stat_word[cantrx_pkg::STAT_EN_DONE] = st.en_done;
      stat_word[cantrx_pkg::STAT_WOKEN] = st.woken;
      stat_word[cantrx_pkg::STAT_TX_BLOCK] = st.tx_block;
   end

   // --------------------------------------------------------------
   // Next state
   // --------------------------------------------------------------
   always_comb begin
      next_st = st;
      next_st.wake_evt = 1'b0;
      next_st.sys_prev = sys_mode;

      // Enabling interval counter; runs only in normal mode
      if (st.mode == cantrx_pkg::MODE_NORMAL && !st.en_done) begin
         if (st.en_cnt == EN_LAST) begin
            next_st.en_done = 1'b1;
         end else begin
            next_st.en_cnt = st.en_cnt + CW'(1);
         end
      end

      // A low input seen before the interval ends is held off until input returns high
      if (st.mode == cantrx_pkg::MODE_NORMAL) begin
         if (!st.en_done && !bus_transmit_input) begin
            next_st.tx_block = 1'b1;
         end else if (bus_transmit_input) begin
            next_st.tx_block = 1'b0;
         end
      end

      // Wake detection only in wake-capable mode, once per arming
      if (st.mode == cantrx_pkg::MODE_WAKE && wake_pattern_seen && !st.woken) begin
         next_st.woken = 1'b1;
         next_st.wake_evt = 1'b1;
      end

      // Only a change into stop or fail-safe rearms; a level rearm would drop the wake
      // indication on the receive output one cycle after a wake in stop mode
      if ((sys_mode == cantrx_pkg::SYS_STOP || sys_mode == cantrx_pkg::SYS_FAILSAFE) &&
          sys_mode != st.sys_prev) begin
         if (!(st.mode == cantrx_pkg::MODE_WAKE && wake_pattern_seen)) begin
            next_st.woken = 1'b0;
         end
      end

      // Write channel
      case (st.wr)
         cantrx_pkg::WR_IDLE: begin
            if (wr_go) begin
               next_st.wr = cantrx_pkg::WR_RESP;
               next_st.bresp = cantrx_pkg::RESP_OKAY;
               if (s_axi_awaddr == cantrx_pkg::ADDR_CTRL) begin
                  if (s_axi_wstrb[0] && allowed && req_mode != st.mode) begin
                     next_st.mode = req_mode;
                     next_st.en_cnt = '0;
                     next_st.en_done = 1'b0;
                     next_st.tx_block = 1'b0;
                     next_st.woken = 1'b0;
                  end else if (s_axi_wstrb[0] && !allowed) begin
                     next_st.irq_stat[cantrx_pkg::IRQ_REJECT] = 1'b1;
                  end
               end else if (s_axi_awaddr == cantrx_pkg::ADDR_IRQ_MASK) begin
                  if (s_axi_wstrb[0]) begin
                     next_st.irq_mask = s_axi_wdata[cantrx_pkg::IRQ_W-1:0];
                  end
               end else if (s_axi_awaddr != cantrx_pkg::ADDR_STAT &&
                            s_axi_awaddr != cantrx_pkg::ADDR_IRQ_STAT) begin
                  next_st.bresp = cantrx_pkg::RESP_SLVERR;
               end
            end
         end
         cantrx_pkg::WR_RESP: begin
            if (s_axi_bready) begin
               next_st.wr = cantrx_pkg::WR_IDLE;
            end
         end
         default: begin
            next_st.wr = cantrx_pkg::WR_IDLE;
         end
      endcase

      // Read channel; reading the sticky status clears it
      if (st.rvalid && s_axi_rready) begin
         next_st.rvalid = 1'b0;
      end
      if (rd_go) begin
         next_st.rvalid = 1'b1;
         next_st.rresp = cantrx_pkg::RESP_OKAY;
         next_st.rdata = 32'h0;
         case (s_axi_araddr)
            cantrx_pkg::ADDR_CTRL: begin
               next_st.rdata[cantrx_pkg::CTRL_MODE_LSB +: 2] = st.mode;
            end
            cantrx_pkg::ADDR_STAT: begin
               next_st.rdata = stat_word;
            end
            cantrx_pkg::ADDR_IRQ_STAT: begin
               next_st.rdata[cantrx_pkg::IRQ_W-1:0] = st.irq_stat;
               next_st.irq_stat = '0;
               // A rejection in this same cycle survives the clear
               if (wr_go && s_axi_awaddr == cantrx_pkg::ADDR_CTRL && s_axi_wstrb[0] &&
                   !allowed) begin
                  next_st.irq_stat[cantrx_pkg::IRQ_REJECT] = 1'b1;
               end
            end
            cantrx_pkg::ADDR_IRQ_MASK: begin
               next_st.rdata[cantrx_pkg::IRQ_W-1:0] = st.irq_mask;
            end
            default: begin
               next_st.rresp = cantrx_pkg::RESP_SLVERR;
            end
         endcase
      end

      // Wake event sets its sticky bit last so it wins over a read clear
      if (next_st.wake_evt) begin
         next_st.irq_stat[cantrx_pkg::IRQ_WAKE] = 1'b1;
      end
   end

   // --------------------------------------------------------------
   // Registers
   // --------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st <= '0;
         st.mode <= cantrx_pkg::MODE_OFF;
         st.wr <= cantrx_pkg::WR_IDLE;
      end else begin
         st <= next_st;
      end
   end

   // --------------------------------------------------------------
   // Pin behaviour
   // --------------------------------------------------------------
   // Driver enabled only in normal mode, dominant only after enabling; receive-only and off never drive.
   // Combinational path from the input keeps delay low enough for 5 Mbaud.
   assign driver_enable = (st.mode == cantrx_pkg::MODE_NORMAL);
   assign bus_drive_dominant = driver_enable && st.en_done && !st.tx_block &&
                               !bus_transmit_input;

   // Receiver runs from its own supply, so the supply pin is not consulted here
   always_comb begin
      case (st.mode)
         cantrx_pkg::MODE_NORMAL: bus_receive_output = !bus_dominant_seen;
         cantrx_pkg::MODE_RXONLY: bus_receive_output = !bus_dominant_seen;
         cantrx_pkg::MODE_WAKE: bus_receive_output = !st.woken;
         default: bus_receive_output = 1'b1;
      endcase
   end

   assign wake_event = st.wake_evt;
   assign irq = |(st.irq_stat & st.irq_mask);

   // Supply pin is only observed as a hint; kept unused by the logic
   logic unused_supply;
   assign unused_supply = transceiver_supply_pin;

endmodule

`default_nettype wire

// ===== inc/cantrx_pkg.sv
// Package with constants, register map and types of the transceiver mode control block
package cantrx_pkg;
   // --------------------------------------------------------------
   // Register map (byte addresses, AXI4-Lite)
   // --------------------------------------------------------------
   localparam logic [7:0] ADDR_CTRL = 8'h00;
   localparam logic [7:0] ADDR_STAT = 8'h04;
   localparam logic [7:0] ADDR_IRQ_STAT = 8'h08;
   localparam logic [7:0] ADDR_IRQ_MASK = 8'h0C;
   localparam int ADDR_W = 8;

   // --------------------------------------------------------------
   // Transceiver mode encodings (mode field)
   // --------------------------------------------------------------
   localparam logic [1:0] MODE_OFF = 2'h0;
   localparam logic [1:0] MODE_WAKE = 2'h1;
   localparam logic [1:0] MODE_RXONLY = 2'h2;
   localparam logic [1:0] MODE_NORMAL = 2'h3;

   // System mode encodings
   localparam logic [2:0] SYS_NORMAL = 3'h0;
   localparam logic [2:0] SYS_STOP = 3'h1;
   localparam logic [2:0] SYS_SLEEP = 3'h2;
   localparam logic [2:0] SYS_RESTART = 3'h3;
   localparam logic [2:0] SYS_FAILSAFE = 3'h4;

   // --------------------------------------------------------------
   // Field positions
   // --------------------------------------------------------------
   localparam int CTRL_MODE_LSB = 0;
   localparam int STAT_EN_DONE = 2;
   localparam int STAT_WOKEN = 3;
   localparam int STAT_TX_BLOCK = 4;
   localparam int IRQ_WAKE = 0;
   localparam int IRQ_REJECT = 1;
   localparam int IRQ_W = 2;

   // --------------------------------------------------------------
   // Timing
   // --------------------------------------------------------------
   localparam int CLK_MHZ = 100;
   localparam int T_EN_NS = 10000;
   localparam int EN_CYCLES = (T_EN_NS * CLK_MHZ + 999) / 1000;
   localparam int MAX_KBAUD = 5000;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // Write channel state machine, one-hot
   typedef enum logic [2:0] {
      WR_IDLE = 3'b001,
      WR_RESP = 3'b010,
      WR_HOLD = 3'b100
   } cantrx_wr_t;
endpackage

// ===== bench/cantrx_mode_ctrl_checker.sv
// Checker of pin behaviour and bus handshakes of the transceiver mode control
`timescale 1ns/1ps
`default_nettype none
module cantrx_mode_ctrl_checker #(
   parameter int EN_CYCLES = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Pins and front end
   input wire logic bus_transmit_input,
   input wire logic bus_receive_output,
   input wire logic bus_dominant_seen,
   input wire logic bus_drive_dominant,
   input wire logic driver_enable,
   input wire logic wake_event,
   input wire logic irq,
   // Register bus answers
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [31:0] s_axi_rdata
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [15:0] on_cnt;
   // Cycles since the driver came on; saturates so a long run never wraps
   always_ff @(posedge aclk) begin
      if (!aresetn || !driver_enable) begin
         on_cnt <= 16'h0000;
      end else if (on_cnt != 16'hFFFF) begin
         on_cnt <= on_cnt + 16'h0001;
      end
   end
   AST_RST_OFF: assert property (disable iff (1'b0) !aresetn |=> !driver_enable && !irq)
      else $error("driver or interrupt active after reset");
   AST_OFF_QUIET: assert property (!driver_enable |-> !bus_drive_dominant)
      else $error("dominant drive while driver is off");
   AST_TX_FOLLOW: assert property (bus_drive_dominant |-> !bus_transmit_input)
      else $error("dominant drive with transmit input high");
   AST_EN_WAIT: assert property (bus_drive_dominant |-> on_cnt >= 16'(EN_CYCLES - 1))
      else $error("dominant drive before enabling interval ended");
   AST_RX_IMAGE: assert property (driver_enable |-> bus_receive_output == !bus_dominant_seen)
      else $error("receive output differs from bus level");
   AST_WAKE_RX: assert property (wake_event |-> !bus_receive_output && !driver_enable)
      else $error("wake without low receive output");
   AST_WAKE_PULSE: assert property (wake_event |=> !wake_event)
      else $error("wake pulse longer than one cycle");
   AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped before ready");
   AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped or changed before ready");
endmodule
`default_nettype wire

// ===== bench/cantrx_host_ctrl_model.sv
// Model of the protocol controller that drives the transmit pin
`timescale 1ns/1ps
`default_nettype none
module cantrx_host_ctrl_model #(
   parameter int BIT_CYC = 20
) (
   // Clock and pins
   input wire logic aclk,
   output logic bus_transmit_input,
   input wire logic bus_receive_output
);
   logic [15:0] seen;
   // Idle level is recessive until a frame is sent
   initial bus_transmit_input = 1'b1;
   // Bits go out msb first at 5 Mbaud; the echo is sampled mid-bit
   task automatic send(input logic [15:0] bits);
      for (int i = 15; i >= 0; i--) begin
         @(posedge aclk);
         bus_transmit_input <= bits[i];
         repeat (BIT_CYC / 2) @(posedge aclk);
         seen[i] = bus_receive_output;
         repeat (BIT_CYC / 2 - 1) @(posedge aclk);
      end
      @(posedge aclk);
      bus_transmit_input <= 1'b1;
   endtask
   // Wrong on purpose: pulls dominant before the driver is ready, then backs off
   task automatic early_low(input int n);
      @(posedge aclk);
      bus_transmit_input <= 1'b0;
      repeat (n) @(posedge aclk);
      bus_transmit_input <= 1'b1;
   endtask
endmodule
`default_nettype wire

// ===== bench/cantrx_mode_ctrl_tb.sv
// Self-checking testbench of the transceiver mode control block
`timescale 1ns/1ps
`default_nettype none
module cantrx_mode_ctrl_tb;
   localparam int EN_CYCLES = 8;
   logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [7:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, rs;
   logic [2:0] sys_mode;
   logic transceiver_supply_pin, bus_transmit_input, bus_receive_output, bus_dominant_seen;
   logic wake_pattern_seen, bus_drive_dominant, driver_enable, wake_event, irq, other_dom;
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   // Wired bus: dominant if this node or another node pulls it
   assign bus_dominant_seen = bus_drive_dominant | other_dom;
   cantrx_mode_ctrl #(.EN_CYCLES(EN_CYCLES)) dut (.*);
   cantrx_host_ctrl_model ctl (.aclk(aclk), .bus_transmit_input(bus_transmit_input),
      .bus_receive_output(bus_receive_output));
   // --------------------------------------------------------------
   // Clock, timeout and helpers
   // --------------------------------------------------------------
   initial begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   // A hang ends the run as a failure
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         n_fail++;
         summarize();
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic summarize();
      $display("Checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   // Write: address and data offered together, each released once taken
   task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
      logic pa, pw;
      pa = 1'b1;
      pw = 1'b1;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (pa || pw) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) pa = 1'b0;
         if (s_axi_wready === 1'b1) pw = 1'b0;
         s_axi_awvalid <= pa;
         s_axi_wvalid <= pw;
      end
      do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
      s_axi_bready <= 1'b1;
      @(posedge aclk);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask
   // Read; ready comes late so the slave must hold its answer
   task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (s_axi_arready !== 1'b1);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
      s_axi_rready <= 1'b1;
      @(posedge aclk);
      rv = s_axi_rdata;
      s_axi_rready <= 1'b0;
      chk(rv & m, e);
   endtask
   task automatic mode(input logic [1:0] m);
      wr(cantrx_pkg::ADDR_CTRL, {30'h0, m}, rs);
   endtask
   task automatic pulse_wake();
      @(posedge aclk);
      wake_pattern_seen <= 1'b1;
      @(posedge aclk);
      wake_pattern_seen <= 1'b0;
      @(posedge aclk);
   endtask
   // --------------------------------------------------------------
   // Scenarios
   // --------------------------------------------------------------
   task automatic t_off();
      rd(cantrx_pkg::ADDR_STAT, 32'h3, 32'h0);
      other_dom <= 1'b1;
      pulse_wake();
      chk(wake_event, 1'b0);
      chk(bus_receive_output, 1'b1);
      other_dom <= 1'b0;
      rd(cantrx_pkg::ADDR_IRQ_STAT, 32'h1, 32'h0);
   endtask
   task automatic t_sys();
      sys_mode <= cantrx_pkg::SYS_STOP;
      mode(cantrx_pkg::MODE_NORMAL);
      chk(irq, 1'b1);
      rd(cantrx_pkg::ADDR_STAT, 32'h3, 32'h0);
      rd(cantrx_pkg::ADDR_IRQ_STAT, 32'h2, 32'h2);
      chk(irq, 1'b0);
      sys_mode <= cantrx_pkg::SYS_SLEEP;
      mode(cantrx_pkg::MODE_RXONLY);
      rd(cantrx_pkg::ADDR_STAT, 32'h3, 32'h0);
      rd(cantrx_pkg::ADDR_IRQ_STAT, 32'h2, 32'h2);
      sys_mode <= cantrx_pkg::SYS_STOP;
      transceiver_supply_pin <= 1'b0;
      mode(cantrx_pkg::MODE_RXONLY);
      rd(cantrx_pkg::ADDR_STAT, 32'h3, 32'h2);
      ctl.send(16'h0F0F);
      chk(ctl.seen, 16'hFFFF);
      other_dom <= 1'b1;
      @(posedge aclk);
      @(posedge aclk);
      chk(bus_receive_output, 1'b0);
      other_dom <= 1'b0;
      sys_mode <= cantrx_pkg::SYS_SLEEP;
      mode(cantrx_pkg::MODE_OFF);
      rd(cantrx_pkg::ADDR_STAT, 32'h3, 32'h0);
      transceiver_supply_pin <= 1'b1;
      sys_mode <= cantrx_pkg::SYS_NORMAL;
   endtask
   task automatic t_enable();
      fork
         mode(cantrx_pkg::MODE_NORMAL);
         ctl.early_low(EN_CYCLES + 6);
         repeat (EN_CYCLES + 6) begin
            @(posedge aclk);
            chk(bus_drive_dominant, 1'b0);
         end
      join
      ctl.send(16'h5A3C);
      chk(ctl.seen, 16'h5A3C);
      mode(cantrx_pkg::MODE_OFF);
      mode(cantrx_pkg::MODE_NORMAL);
      rd(cantrx_pkg::ADDR_STAT, 32'h4, 32'h0);
      repeat (EN_CYCLES) @(posedge aclk);
      rd(cantrx_pkg::ADDR_STAT, 32'h4, 32'h4);
   endtask
   task automatic t_wake();
      mode(cantrx_pkg::MODE_WAKE);
      pulse_wake();
      chk(wake_event, 1'b1);
      chk(irq, 1'b1);
      chk(bus_receive_output, 1'b0);
      rd(cantrx_pkg::ADDR_STAT, 32'h3, 32'h1);
      rd(cantrx_pkg::ADDR_IRQ_STAT, 32'h1, 32'h1);
      chk(irq, 1'b0);
      wr(cantrx_pkg::ADDR_IRQ_MASK, 32'h0, rs);
      mode(cantrx_pkg::MODE_OFF);
      chk(bus_receive_output, 1'b1);
      mode(cantrx_pkg::MODE_WAKE);
      pulse_wake();
      @(posedge aclk);
      chk(irq, 1'b0);
      chk(bus_receive_output, 1'b0);
      rd(cantrx_pkg::ADDR_IRQ_STAT, 32'h1, 32'h1);
      // Wake while staying in stop system mode must keep the receive output low
      sys_mode <= cantrx_pkg::SYS_STOP;
      pulse_wake();
      repeat (2) @(posedge aclk);
      chk(bus_receive_output, 1'b0);
      sys_mode <= cantrx_pkg::SYS_NORMAL;
      wr(8'h10, 32'h0, rs);
      chk(rs, cantrx_pkg::RESP_SLVERR);
   endtask
   // Main sequence
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, other_dom, wake_pattern_seen} = '0;
      s_axi_wstrb = 4'hF;
      sys_mode = cantrx_pkg::SYS_NORMAL;
      transceiver_supply_pin = 1'b1;
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      wr(cantrx_pkg::ADDR_IRQ_MASK, 32'h3, rs);
      t_off();
      t_sys();
      t_enable();
      t_wake();
      summarize();
   end
endmodule
bind cantrx_mode_ctrl cantrx_mode_ctrl_checker #(.EN_CYCLES(EN_CYCLES)) chk_i (.*);
`default_nettype wire
